// ==== common/level_params.svh ====
`ifndef LEVEL_PARAMS_SVH
`define LEVEL_PARAMS_SVH

// timing, in the units as specified
`define CLK_HZ 40000000
`define HEALTH_PULSE_US 350
`define BURST_SPACING_MS 75
`define PULSE_RATE_HZ 170000
`define CHARGE_TIME_US 2

// burst-count figures
`define MAX_BURST_COUNTS 500
`define LOWER_TRIP_COUNTS 250
`define UPPER_TRIP_COUNTS 150
`define HYSTERESIS_COUNTS 3
`define SLOSH_LIMIT_COUNTS 190

// register byte offsets
`define CTRL_OFFSET 12'h000
`define STATUS_OFFSET 12'h004
`define COUNT_OFFSET 12'h008
`define IRQ_STATUS_OFFSET 12'h00c
`define IRQ_MASK_OFFSET 12'h010

// field positions
`define CTRL_RUN_BIT 0
`define STATUS_LOWER_ACTIVE_BIT 0
`define STATUS_UPPER_ACTIVE_BIT 1
`define STATUS_LOWER_DET_BIT 2
`define STATUS_UPPER_DET_BIT 3
`define STATUS_POL_BIT 4
`define STATUS_SLOSH_FILTER_STRAP_BIT 5
`define STATUS_PHASE_LSB 8
`define IRQ_LOWER_BIT 0
`define IRQ_UPPER_BIT 1
`define IRQ_BURST_BIT 2

// reset values
`define CTRL_RESET 1'b1
`define IRQ_MASK_RESET 3'h0

`endif

// ==== common/level_pkg.sv ====
package level_pkg;

	// measurement sequence phases, one-hot
	typedef enum logic [3:0]
	{
		ST_WAIT = 4'b0001,
		ST_HEALTH = 4'b0010,
		ST_BURST = 4'b0100,
		ST_EVAL = 4'b1000
	} phase_t;

	typedef enum logic [2:0]
	{
		REG_NONE,
		REG_CTRL,
		REG_STATUS,
		REG_COUNT,
		REG_IRQ_STATUS,
		REG_IRQ_MASK
	} reg_t;

	// up to 500 burst counts
	typedef logic [8:0] count_t;
	typedef logic [2:0] irq_vec_t;

endpackage

// ==== common/filter_if.sv ====
interface filter_if
#(
	parameter int CW = 8
);
	logic step;
	logic det;
	logic bypass;
	logic active;
	logic [CW-1:0] count;

	modport stage (output step, output det, output bypass, input active, input count);
	modport filter (input step, input det, input bypass, output active, output count);
endinterface

// ==== core/slosh_filter.sv ====
`include "level_params.svh"

module slosh_filter
#(
	parameter int unsigned LIMIT = `SLOSH_LIMIT_COUNTS,
	parameter int CW = 8
)
(
	input wire logic clk_in,
	input wire logic rst_in,
	filter_if.filter fif
);
	localparam logic [CW-1:0] TOP = CW'(LIMIT);

	logic [CW-1:0] cnt_ff;
	logic [CW-1:0] nxt_cnt;
	logic active_ff;

	// bypass parks the counter at the matching end so re-enabling is seamless
	always_comb
	begin
		nxt_cnt = cnt_ff;
		if (fif.bypass)
			nxt_cnt = fif.det ? TOP : '0;
		else if (fif.step && fif.det && cnt_ff != TOP)
			nxt_cnt = cnt_ff + 1'b1;
		else if (fif.step && !fif.det && cnt_ff != '0)
			nxt_cnt = cnt_ff - 1'b1;
	end

	always_ff @(posedge clk_in or posedge rst_in)
	begin
		if (rst_in)
			cnt_ff <= '0;
		else
			cnt_ff <= nxt_cnt;
	end

	// between the ends the output holds: only a full walk flips it
	always_ff @(posedge clk_in or posedge rst_in)
	begin
		if (rst_in)
			active_ff <= 1'b0;
		else if (nxt_cnt == TOP)
			active_ff <= 1'b1;
		else if (nxt_cnt == '0)
			active_ff <= 1'b0;
	end

	assign fif.active = active_ff;
	assign fif.count = cnt_ff;
endmodule

// ==== core/dual_level_output_stage.sv ====
// The APB register port and the register addresses were chosen for this implementation.
`include "level_params.svh"

// Notes on behaviour
// - two independent outputs, lower and upper tier
// - output asserts after crossing and settled filter
// - polarity strap sets sense of both outputs
// - no timeout; asserted while trip crossed
// - polarity strap change applies on the fly
// - outputs tri-stated 350us before each burst
// - health pulse before every burst while run is set, any polarity or state
// - charge pulses near 170kHz, sparse bursts
// - idle between bursts, acquire only in burst
// - trip points 250 and 150 counts
// - three counts hysteresis on both trip points
// - filter counts up/down, limit sets, zero clears
// - filter strap enables or bypasses both filters
module dual_level_output_stage
#(
	parameter int unsigned HEALTH_CYCLES = `HEALTH_PULSE_US * (`CLK_HZ / 1000000),
	parameter int unsigned SPACING_CYCLES = `BURST_SPACING_MS * (`CLK_HZ / 1000),
	parameter int unsigned MAX_COUNTS = `MAX_BURST_COUNTS,
	parameter int unsigned SLOSH_LIMIT = `SLOSH_LIMIT_COUNTS
)
(
	input wire logic CLK_IN,
	input wire logic RST_IN,
	input wire logic PSEL_IN,
	input wire logic PENABLE_IN,
	input wire logic PWRITE_IN,
	input wire logic [11:0] PADDR_IN,
	input wire logic [31:0] PWDATA_IN,
	output logic [31:0] PRDATA_OUT,
	output logic PREADY_OUT,
	output logic PSLVERR_OUT,
	input wire logic OUTPUT_POLARITY_STRAP_IN,
	input wire logic SLOSH_FILTER_STRAP_IN,
	input wire logic SENSE_TRIP_IN,
	output logic CHARGE_PULSE_OUT,
	output logic LOWER_TIER_LEVEL_OUTPUT_OUT,
	output logic LOWER_TIER_LEVEL_OUTPUT_OE_OUT,
	output logic UPPER_TIER_LEVEL_OUTPUT_OUT,
	output logic UPPER_TIER_LEVEL_OUTPUT_OE_OUT,
	output logic IRQ_OUT
);
	import level_pkg::*;

	localparam int unsigned PULSE_PERIOD = `CLK_HZ / `PULSE_RATE_HZ;
	localparam int unsigned CHARGE_CYCLES = `CHARGE_TIME_US * (`CLK_HZ / 1000000);
	localparam int CW = $clog2(SLOSH_LIMIT + 1);
	localparam count_t MAX_CNT = count_t'(MAX_COUNTS);
	localparam count_t HYST = count_t'(`HYSTERESIS_COUNTS);
	localparam count_t TRIP [2] = '{count_t'(`LOWER_TRIP_COUNTS), count_t'(`UPPER_TRIP_COUNTS)};

	function automatic reg_t decode(input logic [11:0] addr);
		case (addr)
			`CTRL_OFFSET: decode = REG_CTRL;
			`STATUS_OFFSET: decode = REG_STATUS;
			`COUNT_OFFSET: decode = REG_COUNT;
			`IRQ_STATUS_OFFSET: decode = REG_IRQ_STATUS;
			`IRQ_MASK_OFFSET: decode = REG_IRQ_MASK;
			default: decode = REG_NONE;
		endcase
	endfunction

	// pin synchronisers: bit 0 polarity, bit 1 filter, bit 2 sense trip
	logic [2:0] pins;
	logic [2:0] meta_ff;
	logic [2:0] sync2_ff;
	logic [2:0] sync3_ff;
	logic [2:0] pin_ff;

	phase_t phase_ff;
	phase_t nxt_phase;
	logic [31:0] timer_ff;
	logic [7:0] pulse_tmr_ff;
	count_t pulse_cnt_ff;
	count_t count_ff;
	logic burst_end;
	logic charge_ff;
	logic step_ff;
	logic [1:0] det_ff;
	logic [1:0] prev_active_ff;
	logic [1:0] active;
	logic [1:0] level_ff;
	logic [1:0] oe_ff;

	logic run_ff;
	irq_vec_t irq_status_ff;
	irq_vec_t irq_mask_ff;
	irq_vec_t irq_ev;
	logic irq_ff;
	logic burst_done_ff;
	logic pready_ff;
	logic pslverr_ff;
	logic [31:0] prdata_ff;
	logic [31:0] rd_data;
	logic access;
	logic wr_en;
	reg_t sel;

	filter_if #(.CW(CW)) fif [2] ();

	assign pins = {SENSE_TRIP_IN, SLOSH_FILTER_STRAP_IN, OUTPUT_POLARITY_STRAP_IN};

	always_ff @(posedge CLK_IN or posedge RST_IN)
	begin
		if (RST_IN)
		begin
			meta_ff <= '0;
			sync2_ff <= '0;
			sync3_ff <= '0;
		end
		else
		begin
			meta_ff <= pins;
			sync2_ff <= meta_ff;
			sync3_ff <= sync2_ff;
		end
	end

	// a pin change counts only once the last two stages agree
	always_ff @(posedge CLK_IN or posedge RST_IN)
	begin
		if (RST_IN)
			pin_ff <= '0;
		else
			pin_ff <= (sync2_ff & ~(sync2_ff ^ sync3_ff)) | (pin_ff & (sync2_ff ^ sync3_ff));
	end

	// a stale trip from the previous burst is ignored until the first pulse ends
	assign burst_end = (pin_ff[2] && pulse_cnt_ff != '0) || pulse_cnt_ff == MAX_CNT;

	always_comb
	begin
		nxt_phase = phase_ff;
		case (phase_ff)
			ST_WAIT:
				if (run_ff && timer_ff >= SPACING_CYCLES - 1)
					nxt_phase = ST_HEALTH;
			ST_HEALTH:
				if (timer_ff >= HEALTH_CYCLES - 1)
					nxt_phase = ST_BURST;
			ST_BURST:
				if (burst_end)
					nxt_phase = ST_EVAL;
			ST_EVAL:
				nxt_phase = ST_WAIT;
			default:
				nxt_phase = ST_WAIT;
		endcase
	end

	always_ff @(posedge CLK_IN or posedge RST_IN)
	begin
		if (RST_IN)
			phase_ff <= ST_WAIT;
		else
			phase_ff <= nxt_phase;
	end

	// saturates so a long stop with run low cannot wrap
	always_ff @(posedge CLK_IN or posedge RST_IN)
	begin
		if (RST_IN)
			timer_ff <= '0;
		else if (nxt_phase != phase_ff)
			timer_ff <= '0;
		else if (timer_ff != 32'hffff_ffff)
			timer_ff <= timer_ff + 32'h1;
	end

	// charge-transfer pulse train, only while a burst runs
	always_ff @(posedge CLK_IN or posedge RST_IN)
	begin
		if (RST_IN)
			pulse_tmr_ff <= '0;
		else if (phase_ff != ST_BURST)
			pulse_tmr_ff <= '0;
		else if (pulse_tmr_ff == 8'(PULSE_PERIOD - 1))
			pulse_tmr_ff <= '0;
		else
			pulse_tmr_ff <= pulse_tmr_ff + 8'h1;
	end

	always_ff @(posedge CLK_IN or posedge RST_IN)
	begin
		if (RST_IN)
			pulse_cnt_ff <= '0;
		else if (phase_ff != ST_BURST)
			pulse_cnt_ff <= '0;
		else if (!burst_end && pulse_tmr_ff == 8'(PULSE_PERIOD - 1))
			pulse_cnt_ff <= pulse_cnt_ff + 9'h1;
	end

	always_ff @(posedge CLK_IN or posedge RST_IN)
	begin
		if (RST_IN)
			charge_ff <= 1'b0;
		else
			charge_ff <= phase_ff == ST_BURST && !burst_end
				&& pulse_tmr_ff < 8'(CHARGE_CYCLES);
	end

	always_ff @(posedge CLK_IN or posedge RST_IN)
	begin
		if (RST_IN)
			count_ff <= MAX_CNT;
		else if (phase_ff == ST_BURST && burst_end)
			count_ff <= pulse_cnt_ff;
	end

	// filters step one cycle after evaluation, so they see the fresh decision
	always_ff @(posedge CLK_IN or posedge RST_IN)
	begin
		if (RST_IN)
			step_ff <= 1'b0;
		else
			step_ff <= phase_ff == ST_EVAL;
	end

	always_ff @(posedge CLK_IN or posedge RST_IN)
	begin
		if (RST_IN)
			burst_done_ff <= 1'b0;
		else
			burst_done_ff <= phase_ff == ST_EVAL;
	end

	for (genvar t = 0; t < 2; t++)
	begin : g_tier
		// fewer counts means more loading, so detection is below the trip point
		always_ff @(posedge CLK_IN or posedge RST_IN)
		begin
			if (RST_IN)
				det_ff[t] <= 1'b0;
			else if (phase_ff == ST_EVAL && !det_ff[t] && count_ff < TRIP[t])
				det_ff[t] <= 1'b1;
			else if (phase_ff == ST_EVAL && det_ff[t] && count_ff >= TRIP[t] + HYST)
				det_ff[t] <= 1'b0;
		end

		assign fif[t].det = det_ff[t];
		assign fif[t].step = step_ff;
		assign fif[t].bypass = ~pin_ff[1];
		assign active[t] = fif[t].active;

		slosh_filter #(
			.LIMIT(SLOSH_LIMIT),
			.CW(CW)
		) u_filter (
			.clk_in(CLK_IN),
			.rst_in(RST_IN),
			.fif(fif[t])
		);

		// level follows live polarity and state, with no hold-off timer
		always_ff @(posedge CLK_IN or posedge RST_IN)
		begin
			if (RST_IN)
				level_ff[t] <= 1'b1;
			else
				level_ff[t] <= ~(active[t] ^ pin_ff[0]);
		end

		always_ff @(posedge CLK_IN or posedge RST_IN)
		begin
			if (RST_IN)
				oe_ff[t] <= 1'b0;
			else
				oe_ff[t] <= phase_ff != ST_HEALTH;
		end

		always_ff @(posedge CLK_IN or posedge RST_IN)
		begin
			if (RST_IN)
				prev_active_ff[t] <= 1'b0;
			else
				prev_active_ff[t] <= active[t];
		end
	end

	assign irq_ev[`IRQ_LOWER_BIT] = active[0] ^ prev_active_ff[0];
	assign irq_ev[`IRQ_UPPER_BIT] = active[1] ^ prev_active_ff[1];
	assign irq_ev[`IRQ_BURST_BIT] = burst_done_ff;

	// apb slave: one wait state, read data is captured on the pready edge, writes commit one edge later
	assign access = PSEL_IN && PENABLE_IN;
	assign sel = decode(PADDR_IN);
	assign wr_en = access && PWRITE_IN && pready_ff;

	always_comb
	begin
		rd_data = '0;
		case (sel)
			REG_CTRL:
				rd_data[`CTRL_RUN_BIT] = run_ff;
			REG_STATUS:
			begin
				rd_data[`STATUS_LOWER_ACTIVE_BIT] = active[0];
				rd_data[`STATUS_UPPER_ACTIVE_BIT] = active[1];
				rd_data[`STATUS_LOWER_DET_BIT] = det_ff[0];
				rd_data[`STATUS_UPPER_DET_BIT] = det_ff[1];
				rd_data[`STATUS_POL_BIT] = pin_ff[0];
				rd_data[`STATUS_SLOSH_FILTER_STRAP_BIT] = pin_ff[1];
				rd_data[`STATUS_PHASE_LSB +: 4] = phase_ff;
			end
			REG_COUNT:
				rd_data[8:0] = count_ff;
			REG_IRQ_STATUS:
				rd_data[2:0] = irq_status_ff;
			REG_IRQ_MASK:
				rd_data[2:0] = irq_mask_ff;
			default:
				rd_data = '0;
		endcase
	end

	always_ff @(posedge CLK_IN or posedge RST_IN)
	begin
		if (RST_IN)
			pready_ff <= 1'b0;
		else
			pready_ff <= access && !pready_ff;
	end

	always_ff @(posedge CLK_IN or posedge RST_IN)
	begin
		if (RST_IN)
			pslverr_ff <= 1'b0;
		else
			pslverr_ff <= access && !pready_ff && sel == REG_NONE;
	end

	always_ff @(posedge CLK_IN or posedge RST_IN)
	begin
		if (RST_IN)
			prdata_ff <= '0;
		else if (access && !pready_ff && !PWRITE_IN)
			prdata_ff <= rd_data;
	end

	always_ff @(posedge CLK_IN or posedge RST_IN)
	begin
		if (RST_IN)
			run_ff <= `CTRL_RESET;
		else if (wr_en && sel == REG_CTRL)
			run_ff <= PWDATA_IN[`CTRL_RUN_BIT];
	end

	always_ff @(posedge CLK_IN or posedge RST_IN)
	begin
		if (RST_IN)
			irq_mask_ff <= `IRQ_MASK_RESET;
		else if (wr_en && sel == REG_IRQ_MASK)
			irq_mask_ff <= PWDATA_IN[2:0];
	end

	// a new event in the clearing cycle survives the clear
	always_ff @(posedge CLK_IN or posedge RST_IN)
	begin
		if (RST_IN)
			irq_status_ff <= '0;
		else if (wr_en && sel == REG_IRQ_STATUS)
			irq_status_ff <= (irq_status_ff & ~PWDATA_IN[2:0]) | irq_ev;
		else
			irq_status_ff <= irq_status_ff | irq_ev;
	end

	always_ff @(posedge CLK_IN or posedge RST_IN)
	begin
		if (RST_IN)
			irq_ff <= 1'b0;
		else
			irq_ff <= |(irq_status_ff & irq_mask_ff);
	end

	assign PRDATA_OUT = prdata_ff;
	assign PREADY_OUT = pready_ff;
	assign PSLVERR_OUT = pslverr_ff;
	assign CHARGE_PULSE_OUT = charge_ff;
	assign LOWER_TIER_LEVEL_OUTPUT_OUT = level_ff[0];
	assign LOWER_TIER_LEVEL_OUTPUT_OE_OUT = oe_ff[0];
	assign UPPER_TIER_LEVEL_OUTPUT_OUT = level_ff[1];
	assign UPPER_TIER_LEVEL_OUTPUT_OE_OUT = oe_ff[1];
	assign IRQ_OUT = irq_ff;
endmodule

// ==== bench/level_stage_chk.sv ====
module level_stage_chk
#(
	parameter int unsigned HEALTH_CYCLES = 40
)
(
	input wire logic CLK_IN,
	input wire logic RST_IN,
	input wire logic PREADY_OUT,
	input wire logic PSLVERR_OUT,
	input wire logic OUTPUT_POLARITY_STRAP_IN,
	input wire logic CHARGE_PULSE_OUT,
	input wire logic LOWER_TIER_LEVEL_OUTPUT_OUT,
	input wire logic LOWER_TIER_LEVEL_OUTPUT_OE_OUT,
	input wire logic UPPER_TIER_LEVEL_OUTPUT_OUT,
	input wire logic UPPER_TIER_LEVEL_OUTPUT_OE_OUT
);
	localparam int CHARGE_HIGH = 80;
	logic drv_ff;
	logic [15:0] hz_cnt_ff;
	logic [7:0] hi_cnt_ff;
	wire logic lo = LOWER_TIER_LEVEL_OUTPUT_OUT;
	wire logic uo = UPPER_TIER_LEVEL_OUTPUT_OUT;
	wire logic loe = LOWER_TIER_LEVEL_OUTPUT_OE_OUT;
	wire logic uoe = UPPER_TIER_LEVEL_OUTPUT_OE_OUT;
	wire logic output_polarity_strap = OUTPUT_POLARITY_STRAP_IN;
	default clocking cb @(posedge CLK_IN); endclocking
	default disable iff (RST_IN);
	// the low phase after reset is not a health pulse, so counting waits for first drive
	always_ff @(posedge CLK_IN or posedge RST_IN)
		if (RST_IN)
			drv_ff <= 1'b0;
		else
			drv_ff <= drv_ff | loe;
	always_ff @(posedge CLK_IN or posedge RST_IN)
		if (RST_IN)
			hz_cnt_ff <= '0;
		else
			hz_cnt_ff <= loe ? 16'h0 : hz_cnt_ff + 16'(drv_ff);
	always_ff @(posedge CLK_IN or posedge RST_IN)
		if (RST_IN)
			hi_cnt_ff <= '0;
		else
			hi_cnt_ff <= CHARGE_PULSE_OUT ? hi_cnt_ff + 8'h1 : 8'h0;
	property p_oe_pair; loe == uoe; endproperty
	a_oe_pair: assert property (p_oe_pair) else $error("enables differ");
	property p_hz_len; $rose(loe) && hz_cnt_ff != 16'h0 |-> hz_cnt_ff == 16'(HEALTH_CYCLES); endproperty
	a_hz_len: assert property (p_hz_len) else $error("release length wrong");
	property p_hz_max; hz_cnt_ff <= 16'(HEALTH_CYCLES); endproperty
	a_hz_max: assert property (p_hz_max) else $error("release too long");
	property p_quiet; $fell(loe) |-> !CHARGE_PULSE_OUT [*8]; endproperty
	a_quiet: assert property (p_quiet) else $error("charge during release");
	property p_chg; $fell(CHARGE_PULSE_OUT) |-> hi_cnt_ff == 8'(CHARGE_HIGH); endproperty
	a_chg: assert property (p_chg) else $error("charge width wrong");
	property p_pol; $changed(output_polarity_strap) ##1 $stable(output_polarity_strap) [*7] |-> lo != $past(lo, 8) && uo != $past(uo, 8);
	endproperty
	a_pol: assert property (p_pol) else $error("sense not inverted");
	property p_resume; $rose(loe) |-> (loe && uoe) [*8]; endproperty
	a_resume: assert property (p_resume) else $error("drive not resumed");
	property p_err; PSLVERR_OUT |-> PREADY_OUT; endproperty
	a_err: assert property (p_err) else $error("error without ready");
	property p_rdy; PREADY_OUT |=> !PREADY_OUT; endproperty
	a_rdy: assert property (p_rdy) else $error("ready too long");
	c_hz: cover property ($fell(loe));
	c_pol: cover property ($changed(output_polarity_strap));
	c_err: cover property (PSLVERR_OUT);
endmodule

// ==== bench/level_host_model.sv ====
module level_host_model
#(
	parameter logic PULL = 1'b1
)
(
	input wire logic clk_in,
	input wire logic rst_in,
	input wire logic charge_in,
	input wire logic [1:0] level_in,
	input wire logic [1:0] oe_in,
	input wire logic [9:0] trip_after_in,
	output logic [1:0] pin_out,
	output logic trip_out
);
	logic chg_ff;
	logic [9:0] pulses_ff;
	// a released line shows the pull resistor, never the last driven value
	assign pin_out = (oe_in & level_in) | (~oe_in & {2{PULL}});
	always_ff @(posedge clk_in or posedge rst_in)
		if (rst_in)
		begin
			chg_ff <= 1'b0;
			pulses_ff <= '0;
			trip_out <= 1'b0;
		end
		else
		begin
			chg_ff <= charge_in;
			if (!oe_in[0])
			begin
				pulses_ff <= '0;
				trip_out <= 1'b0;
			end
			else if (chg_ff && !charge_in)
			begin
				pulses_ff <= pulses_ff + 10'h1;
				trip_out <= pulses_ff + 10'h1 >= trip_after_in;
			end
		end
endmodule

// ==== bench/tb.sv ====
`define CHK(g, e) \
	begin \
		compares++; \
		if ((g) !== (e)) \
		begin \
			fail_count++; \
			$display("mismatch t=%0t got %h exp %h", $time, (g), (e)); \
		end \
	end
module tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk, rst, psel, penable, pwrite, output_polarity_strap, slosh_filter_strap, trip, charge, pready, pslverr, irq, err;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rd, st, msk;
	// each bit comes from its own output port, so these are nets
	wire logic [1:0] lvl;
	wire logic [1:0] oe;
	logic [1:0] pin;
	logic [9:0] n_trip;
	int fail_count, compares;
	dual_level_output_stage #(.HEALTH_CYCLES(40), .SPACING_CYCLES(200), .SLOSH_LIMIT(4))
		u_dual_level_output_stage (.CLK_IN(clk), .RST_IN(rst), .PSEL_IN(psel),
		.PENABLE_IN(penable), .PWRITE_IN(pwrite), .PADDR_IN(paddr), .PWDATA_IN(pwdata),
		.PRDATA_OUT(prdata), .PREADY_OUT(pready), .PSLVERR_OUT(pslverr),
		.OUTPUT_POLARITY_STRAP_IN(output_polarity_strap), .SLOSH_FILTER_STRAP_IN(slosh_filter_strap), .SENSE_TRIP_IN(trip),
		.CHARGE_PULSE_OUT(charge), .LOWER_TIER_LEVEL_OUTPUT_OUT(lvl[0]),
		.LOWER_TIER_LEVEL_OUTPUT_OE_OUT(oe[0]), .UPPER_TIER_LEVEL_OUTPUT_OUT(lvl[1]),
		.UPPER_TIER_LEVEL_OUTPUT_OE_OUT(oe[1]), .IRQ_OUT(irq));
	level_host_model #(.PULL(1'b1)) u_level_host_model (.clk_in(clk), .rst_in(rst),
		.charge_in(charge), .level_in(lvl), .oe_in(oe), .trip_after_in(n_trip),
		.pin_out(pin), .trip_out(trip));
	initial
	begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end
	function automatic logic exp_pin(input logic act, input logic p);
		return act ~^ p;
	endfunction
	function automatic logic [1:0] exp_det(input int n);
		return {n < 150, n < 250};
	endfunction
	task automatic complete_run(input logic timed_out);
		if (timed_out)
			fail_count++;
		if (timed_out)
			$display("mismatch t=%0t wait limit", $time);
		$display("compares=%0d mismatches=%0d", compares, fail_count);
		if (fail_count == 0 && compares > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
		int n;
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		n = 0;
		do
		begin
			@(posedge clk);
			n++;
		end
		while (pready !== 1'b1 && n < 20);
		if (n >= 20)
			complete_run(1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge clk);
	endtask
	task automatic wait_oe(input logic v);
		int n;
		n = 0;
		while (oe[0] !== v && n < 1000)
		begin
			@(posedge clk);
			n++;
		end
		if (n >= 1000)
			complete_run(1'b1);
	endtask
	task automatic wait_burst(input int bound);
		int n;
		n = 0;
		while (irq !== 1'b1 && n < bound)
		begin
			@(posedge clk);
			n++;
		end
		if (n >= bound)
			complete_run(1'b1);
		apb(1'b0, 12'h004, 32'h0);
		st = rd;
		apb(1'b1, 12'h00c, 32'h7);
		repeat (2) @(posedge clk);
		`CHK(irq, 1'b0)
	endtask
	initial
	begin
		void'($urandom(32'h38c82fe2));
		rst = 1'b1;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 12'h000;
		pwdata = 32'h0;
		output_polarity_strap = 1'($urandom);
		slosh_filter_strap = 1'b1;
		n_trip = 10'd2;
		repeat (20) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		apb(1'b0, 12'h000, 32'h0);
		`CHK(rd[0], 1'b1)
		apb(1'b0, 12'h008, 32'h0);
		`CHK(rd[8:0], 9'h1f4)
		apb(1'b0, 12'h0f0, 32'h0);
		`CHK({err, rd}, {1'b1, 32'h0})
		msk = $urandom;
		apb(1'b1, 12'h010, msk);
		apb(1'b0, 12'h010, 32'h0);
		`CHK(rd[2:0], msk[2:0])
		apb(1'b1, 12'h010, 32'h4);
		$display("test registers done");
		for (int k = 1; k <= 4; k++)
		begin
			wait_burst(5000);
			`CHK(st[1:0], k == 4 ? 2'b11 : 2'b00)
			`CHK(st[3:2], exp_det(2))
		end
		`CHK(pin, {2{exp_pin(1'b1, output_polarity_strap)}})
		$display("test filter done");
		wait_oe(1'b0);
		`CHK(pin, 2'b11)
		wait_oe(1'b1);
		output_polarity_strap <= ~output_polarity_strap;
		slosh_filter_strap <= 1'b0;
		n_trip <= 10'd200;
		repeat (10) @(posedge clk);
		`CHK(pin, {2{exp_pin(1'b1, output_polarity_strap)}})
		$display("test polarity done");
		wait_burst(60000);
		`CHK(st[1:0], exp_det(200))
		`CHK(st[5:2], {slosh_filter_strap, output_polarity_strap, exp_det(200)})
		`CHK(pin, {exp_pin(1'b0, output_polarity_strap), exp_pin(1'b1, output_polarity_strap)})
		apb(1'b0, 12'h008, 32'h0);
		`CHK(rd[8:0] === 9'd200 || rd[8:0] === 9'd199, 1'b1)
		$display("test bypass done");
		// re-arm both detections, then land just inside the upper release band
		n_trip <= 10'd2;
		wait_burst(5000);
		`CHK(st[3:0], 4'hf)
		n_trip <= 10'd152;
		wait_burst(60000);
		// 151 counts: above the upper trip point but below its release point
		`CHK(st[3:0], 4'hf)
		`CHK(pin, {2{exp_pin(1'b1, output_polarity_strap)}})
		$display("test hysteresis done");
		complete_run(1'b0);
	end
endmodule
bind dual_level_output_stage level_stage_chk #(.HEALTH_CYCLES(HEALTH_CYCLES)) u_level_stage_chk (
	.CLK_IN(CLK_IN), .RST_IN(RST_IN), .PREADY_OUT(PREADY_OUT), .PSLVERR_OUT(PSLVERR_OUT),
	.OUTPUT_POLARITY_STRAP_IN(OUTPUT_POLARITY_STRAP_IN), .CHARGE_PULSE_OUT(CHARGE_PULSE_OUT),
	.LOWER_TIER_LEVEL_OUTPUT_OUT(LOWER_TIER_LEVEL_OUTPUT_OUT),
	.LOWER_TIER_LEVEL_OUTPUT_OE_OUT(LOWER_TIER_LEVEL_OUTPUT_OE_OUT),
	.UPPER_TIER_LEVEL_OUTPUT_OUT(UPPER_TIER_LEVEL_OUTPUT_OUT),
	.UPPER_TIER_LEVEL_OUTPUT_OE_OUT(UPPER_TIER_LEVEL_OUTPUT_OE_OUT));
